/* File: pfl_host.sv */
`timescale 1ns/1ps
module pfl_host
   import pfl_pkg::*;
(
   input wire logic mclk_i,
   output logic wr_o,
   output logic [3:0] addr_o,
   output logic [PFL_WORD_W-1:0] data_o
);
   initial begin
      wr_o = 1'b0;
      addr_o = 4'h_0;
      data_o = '0;
   end
   task automatic put(input logic [3:0] a, input logic [PFL_WORD_W-1:0] d);
      @(negedge mclk_i);
      wr_o = 1'b1;
      addr_o = a;
      data_o = d;
      @(negedge mclk_i);
      wr_o = 1'b0;
      // idle bus must not look like the last word
      data_o = ~d;
   endtask
   task automatic loop_word(input logic dv, input logic [3:0] ctl);
      put(PFL_ADDR_LOOP, PFL_LOOP_RST | {10'h_000, dv, 5'h_00, ctl, 4'h_0});
   endtask
endmodule

/* File: pfl_pkg.sv */
package pfl_pkg;
   localparam int PFL_WORD_W = 24;
   localparam logic [3:0] PFL_ADDR_SETUP = 4'h_D;
   localparam logic [3:0] PFL_ADDR_LOOP = 4'h_F;
   localparam int PFL_CSR_HI = 23;
   localparam int PFL_CSR_LO = 22;
   localparam int PFL_CPF_HI = 21;
   localparam int PFL_CPF_LO = 18;
   localparam int PFL_TOC_HI = 17;
   localparam int PFL_TOC_LO = 4;
   localparam int PFL_TOC_W = 14;
   localparam int PFL_LOCK_DETECT_QUARTER_RATE_BIT = 13;
   localparam int PFL_AUX_RST_BIT = 7;
   localparam int PFL_MAIN_RST_BIT = 6;
   localparam int PFL_AUX_TRI_BIT = 5;
   localparam int PFL_MAIN_TRI_BIT = 4;
   localparam logic [PFL_TOC_W-1:0] PFL_TOC_HIZ = 14'h_0000;
   localparam logic [PFL_TOC_W-1:0] PFL_TOC_MANUAL = 14'h_0001;
   localparam logic [PFL_TOC_W-1:0] PFL_TOC_LOW = 14'h_0002;
   localparam logic [PFL_TOC_W-1:0] PFL_TOC_HIGH = 14'h_0003;
   localparam logic [PFL_TOC_W-1:0] PFL_TOC_AUTO_MIN = 14'h_0004;
   localparam logic [PFL_WORD_W-1:0] PFL_SETUP_RST = 24'h_0000_0D;
   localparam logic [PFL_WORD_W-1:0] PFL_LOOP_RST = 24'h_0009_0F;
   localparam int PFL_QDIV = 4;
   localparam logic [PFL_TOC_W:0] PFL_CNT_ONE = 15'h_0001;
endpackage

/* File: pfl_quarter_div.sv */
`timescale 1ns/1ps
// divides the comparison strobe by a fixed ratio for lock detect
module pfl_quarter_div
   import pfl_pkg::*;
#(
   parameter int DIV = PFL_QDIV
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic clr_i,
   input wire logic enable_i,
   input wire logic cmp_i,
   output logic cmp_o
);
   logic [1:0] cnt_q;
   logic out_q;

   always_ff @(posedge mclk_i) begin
      if (rst_i || clr_i) begin
         cnt_q <= 2'h_0;
      end else if (cmp_i) begin
         cnt_q <= (cnt_q == 2'(DIV - 1)) ? 2'h_0 : 2'(cnt_q + 2'h_1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         out_q <= 1'b0;
      end else if (enable_i) begin
         out_q <= cmp_i && (cnt_q == 2'(DIV - 1));
      end else begin
         out_q <= cmp_i;
      end
   end

   assign cmp_o = out_q;
endmodule

/* File: pfl_regs.sv */
`timescale 1ns/1ps
// How it works
// - cycle-slip select comes from bits 23:22 of the setup word and drives slip reduction.
// - the 4-bit fastlock pump current code comes from bits 21:18 of the setup word.
// - the 14-bit timeout comes from bits 17:4 and steers both fastlock and the fastlock pin.
// - timeout codes 0 to 3 disable automatic fastlock and make the pin a general output.
// - timeout codes 4 and up enable fastlock and make the pin the fastlock indicator.
// - automatic fastlock lasts twice the timeout value in comparison cycles.
// - code 0 floats the pin, code 2 drives it low, code 3 drives it high.
// - code 1 forces fastlock continuously with no timeout and drives the pin low.
// - the pump multiplier is the current code plus one, 1x to 16x.
// - slip code 0 is off, codes 1, 2, 3 reduce the sample rate by 1/2, 1/4, 1/16.
// - lock-detect divide passes the main comparison rate divided by four to lock detect.
// - counter reset clears a loop's counters, floats its pump, and fires on power-up.
// - pump tri-state floats a loop's pump while its counters run on.
module pfl_regs
   import pfl_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [3:0] addr_i,
   input wire logic [PFL_WORD_W-1:0] data_i,
   input wire logic div_load_i,
   input wire logic cmp_i,
   input wire logic powerup_i,
   output logic fastlock_o,
   output logic [4:0] pump_mult_o,
   output logic [3:0] pump_code_o,
   output logic [1:0] cycle_slip_reduction_sel_o,
   output logic [4:0] slip_div_o,
   output logic fastlock_output_pin_o,
   output logic fastlock_output_pin_oe_n_o,
   output logic lock_detect_cmp_o,
   output logic main_counter_reset_o,
   output logic aux_counter_reset_o,
   output logic main_pump_hiz_o,
   output logic aux_pump_hiz_o
);
   typedef enum logic [1:0] {
      PFL_IDLE,
      PFL_TIMED,
      PFL_MANUAL
   } pfl_state_t;

   logic [PFL_WORD_W-1:0] setup_q;
   logic [PFL_WORD_W-1:0] loop_q;
   logic [PFL_TOC_W-1:0] toc;
   logic [PFL_TOC_W:0] cnt_q;
   logic setup_we;
   logic loop_we;
   logic timed_tick;
   logic timed_done;
   logic [2:0] pwr_sync_q;
   logic pwr_agree;
   logic pwr_filt_q;
   logic pwr_rst_q;
   pfl_state_t state_q;
   pfl_state_t state_d;

   function automatic logic [4:0] pfl_slip_div(input logic [1:0] sel);
      case (sel)
         2'h_1: pfl_slip_div = 5'h_02;
         2'h_2: pfl_slip_div = 5'h_04;
         2'h_3: pfl_slip_div = 5'h_10;
         default: pfl_slip_div = 5'h_01;
      endcase
   endfunction

   // a word is taken only on a write strobe that carries its own address
   function automatic logic pfl_hit(input logic wr, input logic [3:0] addr,
      input logic [3:0] mine);
      pfl_hit = wr && (addr == mine);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // programming words

   // the low nibble of each word is its address; any other address is ignored
   assign setup_we = pfl_hit(wr_i, addr_i, PFL_ADDR_SETUP);
   assign loop_we = pfl_hit(wr_i, addr_i, PFL_ADDR_LOOP);

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         setup_q <= PFL_SETUP_RST;
      end else if (setup_we) begin
         setup_q <= data_i;
      end
   end

   // only the control bits matter; the fixed pattern is the host's duty
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         loop_q <= PFL_LOOP_RST;
      end else if (loop_we) begin
         loop_q <= data_i;
      end
   end

   assign toc = setup_q[PFL_TOC_HI:PFL_TOC_LO];
   assign cycle_slip_reduction_sel_o = setup_q[PFL_CSR_HI:PFL_CSR_LO];
   assign slip_div_o = pfl_slip_div(cycle_slip_reduction_sel_o);
   assign pump_code_o = setup_q[PFL_CPF_HI:PFL_CPF_LO];
   assign pump_mult_o = 5'(pump_code_o) + 5'h_01;

   ////////////////////////////////////////////////////////////////////////////////
   // fastlock sequencing

   // one comparison event spent in the timed state, and the last one of the period
   assign timed_tick = (state_q == PFL_TIMED) && cmp_i;
   assign timed_done = timed_tick && (cnt_q == PFL_CNT_ONE);

   always_comb begin
      state_d = state_q;
      if (toc == PFL_TOC_MANUAL) begin
         state_d = PFL_MANUAL;
      end else if (toc < PFL_TOC_AUTO_MIN) begin
         state_d = PFL_IDLE;
      end else if (div_load_i) begin
         state_d = PFL_TIMED;
      end else begin
         case (state_q)
            PFL_TIMED: begin
               if (timed_done) begin
                  state_d = PFL_IDLE;
               end
            end
            PFL_MANUAL: state_d = PFL_IDLE;
            default: state_d = state_q;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_q <= PFL_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // counts comparison cycles; twice the code, so one extra bit
   // only a divider load reloads it, so rewriting the word alone does not
   // restart a running period
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else if (div_load_i) begin
         cnt_q <= {toc, 1'b0};
      end else if (timed_tick && cnt_q != '0) begin
         cnt_q <= cnt_q - PFL_CNT_ONE;
      end
   end

   // timed and manual fastlock look the same to the pump; only the pin differs
   assign fastlock_o = (state_q != PFL_IDLE);

   ////////////////////////////////////////////////////////////////////////////////
   // fastlock pin

   always_comb begin
      fastlock_output_pin_oe_n_o = 1'b0;
      case (toc)
         PFL_TOC_HIZ: begin
            fastlock_output_pin_oe_n_o = 1'b1;
            fastlock_output_pin_o = 1'b0;
         end
         PFL_TOC_MANUAL: fastlock_output_pin_o = 1'b0;
         PFL_TOC_LOW: fastlock_output_pin_o = 1'b0;
         PFL_TOC_HIGH: fastlock_output_pin_o = 1'b1;
         // indicator is driven low while fastlock is active and driven high afterwards
         default: fastlock_output_pin_o = (state_q != PFL_TIMED);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // loop reset and tri-state

   // the power-up level comes partly from the enable pin, so it is synchronised;
   // no reset here: the chain settles while rst_i is held
   always_ff @(posedge mclk_i) begin
      pwr_sync_q <= {pwr_sync_q[1:0], powerup_i};
   end

   // a change counts only once the last two stages agree
   assign pwr_agree = (pwr_sync_q[2] == pwr_sync_q[1]);

   // the filter follows the pin through reset, so a level that is already high
   // when reset ends gives no false power-up edge
   always_ff @(posedge mclk_i) begin
      if (rst_i || pwr_agree) begin
         pwr_filt_q <= pwr_sync_q[2];
      end
   end

   // one-cycle counter reset on each settled rising edge of power-up
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pwr_rst_q <= 1'b0;
      end else begin
         pwr_rst_q <= pwr_agree && pwr_sync_q[2] && !pwr_filt_q;
      end
   end

   assign main_counter_reset_o = loop_q[PFL_MAIN_RST_BIT] || pwr_rst_q;
   assign aux_counter_reset_o = loop_q[PFL_AUX_RST_BIT] || pwr_rst_q;
   assign main_pump_hiz_o = main_counter_reset_o || loop_q[PFL_MAIN_TRI_BIT];
   assign aux_pump_hiz_o = aux_counter_reset_o || loop_q[PFL_AUX_TRI_BIT];

   pfl_quarter_div #(
      .DIV(PFL_QDIV)
   ) u_qdiv (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .clr_i(main_counter_reset_o),
      .enable_i(loop_q[PFL_LOCK_DETECT_QUARTER_RATE_BIT]),
      .cmp_i(cmp_i),
      .cmp_o(lock_detect_cmp_o)
   );
endmodule

/* File: pfl_regs_chk.sv */
`timescale 1ns/1ps
module pfl_regs_chk
   import pfl_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [3:0] addr_i,
   input wire logic [PFL_WORD_W-1:0] data_i,
   input wire logic div_load_i,
   input wire logic cmp_i,
   input wire logic powerup_i,
   input wire logic fastlock_o,
   input wire logic [4:0] pump_mult_o,
   input wire logic [3:0] pump_code_o,
   input wire logic [1:0] cycle_slip_reduction_sel_o,
   input wire logic [4:0] slip_div_o,
   input wire logic fastlock_output_pin_o,
   input wire logic fastlock_output_pin_oe_n_o,
   input wire logic lock_detect_cmp_o,
   input wire logic main_counter_reset_o,
   input wire logic aux_counter_reset_o,
   input wire logic main_pump_hiz_o,
   input wire logic aux_pump_hiz_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic sw;
   logic [13:0] toc;
   assign sw = wr_i && addr_i == PFL_ADDR_SETUP;
   assign toc = data_i[PFL_TOC_HI:PFL_TOC_LO];
   a_mult_plus_one: assert property (
      pump_mult_o == pump_code_o + 5'h_01) else $error("pump multiplier wrong");
   a_slip_div_map: assert property (
      slip_div_o == ((cycle_slip_reduction_sel_o == 2'h_3) ? 5'h_10 :
      5'h_01 << cycle_slip_reduction_sel_o)) else $error("slip divisor wrong");
   a_fields_loaded: assert property (sw |=> pump_code_o == $past(data_i[21:18]) &&
      cycle_slip_reduction_sel_o == $past(data_i[23:22])) else $error("fields not loaded");
   a_pin_float: assert property (sw && toc == PFL_TOC_HIZ |->
      ##[1:2] fastlock_output_pin_oe_n_o) else $error("pin not floated");
   a_pin_low_high: assert property (sw && toc inside {2, 3} |=>
      !fastlock_output_pin_oe_n_o && fastlock_output_pin_o == $past(toc[0]))
      else $error("gpio pin");
   a_manual_forced: assert property (sw && toc == PFL_TOC_MANUAL |-> ##[1:2]
      fastlock_o && !fastlock_output_pin_o) else $error("manual fastlock");
   a_ld_follows_cmp: assert property (
      lock_detect_cmp_o |-> $past(cmp_i)) else $error("lock detect pulse uncaused");
   a_reset_floats_pump: assert property (
      (!main_counter_reset_o || main_pump_hiz_o) && (!aux_counter_reset_o || aux_pump_hiz_o))
      else $error("counter reset without pump float");
   a_powerup_reset: assert property ($rose(powerup_i) |-> ##[1:4]
      main_counter_reset_o && aux_counter_reset_o) else $error("no power-up reset");
   a_loop_bits_applied: assert property (wr_i && addr_i == PFL_ADDR_LOOP |=>
      (!$past(data_i[PFL_MAIN_RST_BIT]) || main_counter_reset_o) &&
      (!$past(data_i[PFL_AUX_RST_BIT]) || aux_counter_reset_o) &&
      (!$past(data_i[PFL_MAIN_TRI_BIT]) || main_pump_hiz_o) &&
      (!$past(data_i[PFL_AUX_TRI_BIT]) || aux_pump_hiz_o)) else $error("loop bits not applied");
endmodule
bind pfl_regs pfl_regs_chk chk (.*);

/* File: pfl_regs_test.sv */
`timescale 1ns/1ps
module pfl_regs_test import pfl_pkg::*;;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic div_load_i = 1'b0;
   logic cmp_i = 1'b0;
   logic powerup_i = 1'b0;
   logic wr_i, fastlock_o, fastlock_output_pin_o, fastlock_output_pin_oe_n_o, lock_detect_cmp_o;
   logic main_counter_reset_o, aux_counter_reset_o, main_pump_hiz_o, aux_pump_hiz_o, seen;
   logic [3:0] addr_i, pump_code_o;
   logic [1:0] cycle_slip_reduction_sel_o;
   logic [4:0] pump_mult_o, slip_div_o;
   logic [PFL_WORD_W-1:0] data_i;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int ld_cnt = 0;
   typedef struct packed {
      logic [23:0] w;
      logic [4:0] mult;
      logic [4:0] sd;
      logic [1:0] pin;
   } pfl_row_t;
   // each row sets slip, fastlock current and timeout together in one word
   pfl_row_t rows [4] = '{'{24'h_7C00_2D, 5'h_10, 5'h_02, 2'h_0},
      '{24'h_9C00_3D, 5'h_08, 5'h_04, 2'h_1}, '{24'h_C400_0D, 5'h_02, 5'h_10, 2'h_2},
      '{24'h_0000_5D, 5'h_01, 5'h_01, 2'h_1}};
   logic [3:0] lexp [4] = '{4'h_2, 4'h_1, 4'h_A, 4'h_5};
   pfl_regs dut (.*);
   pfl_host host (.mclk_i(mclk_i), .wr_o(wr_i), .addr_o(addr_i), .data_o(data_i));
   initial forever #12.5 mclk_i = ~mclk_i;
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: saw %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         @(negedge mclk_i);
         cmp_i = 1'b1;
         @(negedge mclk_i);
         cmp_i = 1'b0;
      end
      @(negedge mclk_i);
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (lock_detect_cmp_o === 1'b1) ld_cnt++;
      if (cyc == 3000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      repeat (8) @(negedge mclk_i);
      rst_i = 1'b0;
      check({fastlock_o, fastlock_output_pin_oe_n_o}, 8'h_01);
      foreach (rows[i]) begin
         host.put(PFL_ADDR_SETUP, rows[i].w);
         @(negedge mclk_i);
         check({cycle_slip_reduction_sel_o, pump_code_o}, rows[i].w[23:18]);
         check({pump_mult_o, slip_div_o[2:0]}, {rows[i].mult, rows[i].sd[2:0]});
         check(slip_div_o, rows[i].sd);
         check({fastlock_output_pin_oe_n_o, fastlock_output_pin_o & ~fastlock_output_pin_oe_n_o},
            rows[i].pin);
      end
      $display("row table done");
      host.put(PFL_ADDR_SETUP, 24'h_0000_4D);
      @(negedge mclk_i);
      div_load_i = 1'b1;
      @(negedge mclk_i);
      div_load_i = 1'b0;
      @(negedge mclk_i);
      check({fastlock_o, fastlock_output_pin_o}, 8'h_02);
      pulse(7);
      check(fastlock_o, 1'b1);
      pulse(1);
      check({fastlock_o, fastlock_output_pin_o}, 8'h_01);
      host.put(PFL_ADDR_SETUP, 24'h_0000_1D);
      pulse(20);
      check({fastlock_o, fastlock_output_pin_o, fastlock_output_pin_oe_n_o}, 8'h_04);
      $display("fastlock timing done");
      for (int i = 0; i < 4; i++) begin
         host.loop_word(1'b1, 4'h_1 << i);
         @(negedge mclk_i);
         check({main_counter_reset_o, aux_counter_reset_o, main_pump_hiz_o, aux_pump_hiz_o},
            lexp[i]);
      end
      ld_cnt = 0;
      pulse(8);
      check(ld_cnt, 2);
      host.loop_word(1'b0, 4'h_0);
      ld_cnt = 0;
      pulse(3);
      check(ld_cnt, 3);
      seen = 1'b0;
      powerup_i = 1'b1;
      // the pin passes a synchroniser first, so allow for its latency
      repeat (6) begin
         @(negedge mclk_i);
         seen = seen | (main_counter_reset_o & aux_counter_reset_o);
      end
      check(seen, 1'b1);
      $display("loop word done");
      host.put(PFL_ADDR_SETUP, 24'h_0000_1D);
      host.loop_word(1'b1, 4'h_F);
      check(fastlock_o, 1'b1);
      // mid-run reset with power-up still high must give no power-up pulse
      rst_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      rst_i = 1'b0;
      check({fastlock_o, fastlock_output_pin_oe_n_o, main_pump_hiz_o}, 8'h_02);
      repeat (3) @(negedge mclk_i);
      check({aux_pump_hiz_o, main_counter_reset_o, pump_code_o}, 8'h_00);
      $display("reset done");
      stop_test();
   end
endmodule
